/* File: sie_consts.svh */
// constants for the stack and interrupt entry block
`ifndef SIE_CONSTS_SVH
`define SIE_CONSTS_SVH

`define SIE_NUM_SRC          8
`define SIE_IO_ADDR_SPL      6'h3D
`define SIE_IO_ADDR_SPH      6'h3E
`define SIE_IO_ADDR_STATUS_WORD     6'h3F
`define SIE_IO_ADDR_CTRL     6'h35
`define SIE_IO_ADDR_FLAGS    6'h1C
`define SIE_IO_ADDR_ENABLES  6'h1D
`define SIE_STATUS_WORD_I_BIT       7
`define SIE_CTRL_VECTOR_TABLE_SELECT_BIT   1
`define SIE_TOP_OF_DATA      16'h04FF
`define SIE_ENTRY_CYCLES     3'h4
`define SIE_RETURN_CYCLES    3'h4
`define SIE_WAKE_EXTRA       3'h4
`define SIE_VEC_STRIDE       2
`define SIE_BOOT_BASE        13'h1C00
`define SIE_PC_BITS          13

`endif

/* File: sie_pkg.sv */
// types for the stack and interrupt entry block
`include "sie_consts.svh"
package sie_pkg;
	typedef enum logic [2:0] {
		SIE_OP_NONE,
		SIE_OP_PUSH1,
		SIE_OP_POP1,
		SIE_OP_CALL,
		SIE_OP_RET,
		SIE_OP_RETURN_FROM_INTERRUPT
	} sie_op_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} sie_io_s;

	typedef struct packed {
		sie_op_e    op;
		logic       insn_done;
		logic       cli;
		logic       sei;
		logic       asleep;
		logic [12:0] pc;
	} sie_core_s;

	typedef logic [`SIE_NUM_SRC-1:0] sie_src_t;
endpackage

/* File: sie_prio.sv */
// fixed priority picker: lowest index wins
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.svh"
module sie_prio (
	input  wire logic [`SIE_NUM_SRC-1:0] req,
	output logic                         any,
	output logic [2:0]                   idx
);
	always_comb begin
		any = 1'b0;
		idx = 3'h0;
		for (int i = `SIE_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = 3'(i);
			end
		end
	end
endmodule // sie_prio
`default_nettype wire

/* File: sie_core.sv */
// stack pointer and interrupt entry and return sequencer
// Summary of operation
// RULE_01 - push lowers pointer one; call or interrupt entry lowers it two
// RULE_02 - pop raises pointer one; return or interrupt return raises it two
// RULE_03 - pointer is high and low byte registers at io 0x3E and 0x3D
// RULE_04 - software sets pointer above 0x0100 before calls or enabling interrupts
// RULE_05 - interrupt taken only with own enable and global enable both set
// RULE_06 - per source vector; lower index higher priority; reset highest
// RULE_07 - select bit moves vectors to boot start; fuse moves reset vector
// RULE_08 - boot lock bits suppress interrupts depending on current program counter
// RULE_09 - accepting an interrupt clears global enable
// RULE_10 - interrupt return sets global enable
// RULE_11 - vectoring clears flag of a flag-type source
// RULE_12 - writing one clears a flag, zero leaves it
// RULE_13 - flag set while disabled is held until enabled and served or cleared
// RULE_14 - level sources request only while condition present
// RULE_15 - one main instruction runs after return before next interrupt
// RULE_16 - software saves and restores status word in handlers
// RULE_17 - clear-enable instruction blocks interrupts at once, same cycle too
// RULE_18 - instruction after set-enable runs before any pending interrupt
// RULE_19 - entry takes four cycles pushing program counter, then vector
// RULE_20 - interrupt waits for multi-cycle instruction to complete
// RULE_21 - waking from sleep adds four entry cycles
// RULE_22 - return takes four cycles, pops two bytes, pointer up two, enable set
// RULE_23 - reset sets pointer to top of data memory
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.svh"
module sie_core
	import sie_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire sie_pkg::sie_io_s      io,
	input  wire sie_pkg::sie_core_s    core,
	input  wire sie_pkg::sie_src_t     src_event,
	input  wire sie_pkg::sie_src_t     src_level,
	input  wire sie_pkg::sie_src_t     src_is_level,
	input  wire logic                  boot_reset_fuse,
	input  wire logic                  irq_lock_app,
	input  wire logic                  irq_lock_boot,
	input  wire logic                  pc_in_boot,
	input  wire logic [7:0]            stack_rdata,
	output logic [7:0]                 io_rdata,
	output logic [15:0]                stack_addr,
	output logic                       stack_wr,
	output logic                       stack_rd,
	output logic [7:0]                 stack_wdata,
	output logic                       irq_busy,
	output logic                       vector_valid,
	output logic [12:0]                vector_pc,
	output logic [12:0]                reset_pc,
	output logic [12:0]                return_pc,
	output logic                       return_valid,
	output logic [7:0]                 status_word
);
	import sie_pkg::*;

	typedef enum logic [2:0] {
		SIE_IDLE,
		SIE_WAKE,
		SIE_ENTRY,
		SIE_RETURN
	} sie_state_e;

	sie_state_e  state_reg;
	logic [15:0] sp_reg;
	logic [7:0]  status_reg;
	logic [7:0]  ctrl_reg;
	sie_src_t    flag_reg;
	sie_src_t    enable_reg;
	logic [2:0]  cnt_reg;
	logic [2:0]  vec_reg;
	logic        hold_reg;
	logic [12:0] pc_reg;
	logic [7:0]  ret_hi_reg;
	logic [12:0] ret_pc_reg;
	logic        ret_valid_reg;
	logic        vec_valid_reg;
	logic [12:0] vec_pc_reg;
	logic [12:0] rst_pc_reg;

	sie_src_t    req;
	logic        any_req;
	logic [2:0]  pick;
	logic        locked;
	logic        accept;
	logic        g_en;

	// ----------------------------------------------------------------
	// request gathering
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < `SIE_NUM_SRC; g++) begin : g_req
			// level sources bypass the flag entirely
			assign req[g] = enable_reg[g] &&
				(src_is_level[g] ? src_level[g] : flag_reg[g]); // RULE_13 RULE_14
		end
	endgenerate

	sie_prio u_prio (
		.req (req),
		.any (any_req),
		.idx (pick)
	);

	assign locked = pc_in_boot ? irq_lock_boot : irq_lock_app; // RULE_08
	assign g_en   = status_reg[`SIE_STATUS_WORD_I_BIT] && !core.cli; // RULE_17
	// hold_reg covers the instruction after return or set-enable
	assign accept = (state_reg == SIE_IDLE) && core.insn_done && !hold_reg &&
		g_en && any_req && !locked; // RULE_05 RULE_15 RULE_18 RULE_20

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= SIE_IDLE;
			cnt_reg   <= 3'h0;
			vec_reg   <= 3'h0;
		end else begin
			case (state_reg)
				SIE_IDLE: begin
					if (accept) begin
						vec_reg   <= pick; // RULE_06
						state_reg <= core.asleep ? SIE_WAKE : SIE_ENTRY;
						cnt_reg   <= core.asleep ? `SIE_WAKE_EXTRA : `SIE_ENTRY_CYCLES; // RULE_21
					end else if (core.op == SIE_OP_RETURN_FROM_INTERRUPT && core.insn_done) begin
						state_reg <= SIE_RETURN;
						cnt_reg   <= `SIE_RETURN_CYCLES; // RULE_22
					end
				end
				SIE_WAKE: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= SIE_ENTRY;
						cnt_reg   <= `SIE_ENTRY_CYCLES;
					end
				end
				SIE_ENTRY, SIE_RETURN: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= SIE_IDLE; // RULE_19
					end
				end
				default: state_reg <= SIE_IDLE;
			endcase
		end
	end

	// one instruction must run after return or set-enable
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hold_reg <= 1'b0;
		end else if ((state_reg == SIE_RETURN && cnt_reg == 3'h1) ||
			(core.sei && core.insn_done)) begin
			hold_reg <= 1'b1; // RULE_15 RULE_18
		end else if (state_reg == SIE_IDLE && core.insn_done) begin
			hold_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// stack pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sp_reg <= `SIE_TOP_OF_DATA; // RULE_23
		end else if (state_reg == SIE_ENTRY && cnt_reg >= 3'h3) begin
			sp_reg <= sp_reg - 16'h0001; // RULE_01
		end else if (state_reg == SIE_RETURN && cnt_reg >= 3'h3) begin
			sp_reg <= sp_reg + 16'h0001; // RULE_02 RULE_22
		end else if (state_reg == SIE_IDLE && core.insn_done &&
			core.op inside {SIE_OP_PUSH1, SIE_OP_POP1, SIE_OP_CALL, SIE_OP_RET}) begin
			case (core.op)
				SIE_OP_PUSH1: sp_reg <= sp_reg - 16'h0001; // RULE_01
				SIE_OP_CALL:  sp_reg <= sp_reg - 16'h0002; // RULE_01
				SIE_OP_POP1:  sp_reg <= sp_reg + 16'h0001; // RULE_02
				SIE_OP_RET:   sp_reg <= sp_reg + 16'h0002; // RULE_02
				default:      sp_reg <= sp_reg;
			endcase
		end else if (io.wr && io.addr == `SIE_IO_ADDR_SPL) begin
			sp_reg[7:0] <= io.wdata; // RULE_03
		end else if (io.wr && io.addr == `SIE_IO_ADDR_SPH) begin
			sp_reg[15:8] <= io.wdata; // RULE_03
		end
	end

	// ----------------------------------------------------------------
	// status word and control
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			status_reg <= 8'h00;
		end else if (accept) begin
			status_reg[`SIE_STATUS_WORD_I_BIT] <= 1'b0; // RULE_09
		end else if (state_reg == SIE_RETURN && cnt_reg == 3'h1) begin
			status_reg[`SIE_STATUS_WORD_I_BIT] <= 1'b1; // RULE_10 RULE_22
		end else if (core.cli) begin
			status_reg[`SIE_STATUS_WORD_I_BIT] <= 1'b0; // RULE_17
		end else if (core.sei) begin
			status_reg[`SIE_STATUS_WORD_I_BIT] <= 1'b1;
		end else if (io.wr && io.addr == `SIE_IO_ADDR_STATUS_WORD) begin
			status_reg <= io.wdata; // RULE_16
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_reg   <= 8'h00;
			enable_reg <= '0;
		end else if (io.wr && io.addr == `SIE_IO_ADDR_CTRL) begin
			ctrl_reg <= io.wdata;
		end else if (io.wr && io.addr == `SIE_IO_ADDR_ENABLES) begin
			enable_reg <= io.wdata;
		end
	end

	// ----------------------------------------------------------------
	// pending flags: hardware set beats any clear
	// ----------------------------------------------------------------
	generate
		for (genvar f = 0; f < `SIE_NUM_SRC; f++) begin : g_flag
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					flag_reg[f] <= 1'b0;
				end else if (src_event[f] && !src_is_level[f]) begin
					flag_reg[f] <= 1'b1; // RULE_13
				end else if (accept && pick == 3'(f)) begin
					flag_reg[f] <= 1'b0; // RULE_11
				end else if (io.wr && io.addr == `SIE_IO_ADDR_FLAGS && io.wdata[f]) begin
					flag_reg[f] <= 1'b0; // RULE_12
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// stack memory traffic and vectors
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pc_reg <= 13'h0000;
		end else if (accept) begin
			pc_reg <= core.pc;
		end
	end

	always_comb begin
		stack_addr  = sp_reg;
		stack_wr    = (state_reg == SIE_ENTRY) && (cnt_reg >= 3'h3); // RULE_19
		stack_rd    = (state_reg == SIE_RETURN) && (cnt_reg == 3'h3 || cnt_reg == 3'h2); // RULE_22
		stack_wdata = (cnt_reg == 3'h4) ? pc_reg[7:0] : {3'h0, pc_reg[12:8]};
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ret_hi_reg    <= 8'h00;
			ret_pc_reg    <= 13'h0000;
			ret_valid_reg <= 1'b0;
		end else begin
			ret_valid_reg <= 1'b0;
			// pointer steps up before each read, since it rests on the free byte
			if (state_reg == SIE_RETURN && cnt_reg == 3'h3) begin
				ret_hi_reg <= stack_rdata;
			end
			if (state_reg == SIE_RETURN && cnt_reg == 3'h2) begin
				ret_pc_reg <= {ret_hi_reg[4:0], stack_rdata};
			end
			if (state_reg == SIE_RETURN && cnt_reg == 3'h1) begin
				ret_valid_reg <= 1'b1; // RULE_22
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			vec_valid_reg <= 1'b0;
			vec_pc_reg    <= 13'h0000;
			rst_pc_reg    <= 13'h0000;
		end else begin
			rst_pc_reg    <= boot_reset_fuse ? `SIE_BOOT_BASE : 13'h0000; // RULE_07
			vec_valid_reg <= (state_reg == SIE_ENTRY) && (cnt_reg == 3'h1); // RULE_19
			// vector 0 is reset, so source n lands at slot n+1
			vec_pc_reg <= (ctrl_reg[`SIE_CTRL_VECTOR_TABLE_SELECT_BIT] ? `SIE_BOOT_BASE : 13'h0000) +
				13'((vec_reg + 3'h1) * `SIE_VEC_STRIDE); // RULE_06 RULE_07
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			io_rdata <= 8'h00;
		end else if (io.rd) begin
			case (io.addr)
				`SIE_IO_ADDR_SPL:     io_rdata <= sp_reg[7:0];
				`SIE_IO_ADDR_SPH:     io_rdata <= sp_reg[15:8];
				`SIE_IO_ADDR_STATUS_WORD:    io_rdata <= status_reg;
				`SIE_IO_ADDR_CTRL:    io_rdata <= ctrl_reg;
				`SIE_IO_ADDR_FLAGS:   io_rdata <= flag_reg;
				`SIE_IO_ADDR_ENABLES: io_rdata <= enable_reg;
				default:              io_rdata <= 8'h00;
			endcase
		end
	end

	assign irq_busy     = (state_reg != SIE_IDLE);
	assign vector_valid = vec_valid_reg;
	assign vector_pc    = vec_pc_reg;
	assign reset_pc     = rst_pc_reg;
	assign return_pc    = ret_pc_reg;
	assign return_valid = ret_valid_reg;
	assign status_word  = status_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_reset_sp_top: assert property (@(posedge clk_sys) $fell(reset) |-> sp_reg == `SIE_TOP_OF_DATA) // RULE_23
		else $error("pointer not at top after reset");
	a_push_one: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == SIE_IDLE && core.insn_done && !accept && core.op == SIE_OP_PUSH1 && !io.wr
		|=> sp_reg == $past(sp_reg) - 16'h0001) // RULE_01
		else $error("push did not lower pointer by one");
	a_ret_two: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == SIE_IDLE && core.insn_done && !accept && core.op == SIE_OP_RET
		|=> sp_reg == $past(sp_reg) + 16'h0002) // RULE_02
		else $error("return did not raise pointer by two");
	a_entry_len: assert property (@(posedge clk_sys) disable iff (reset)
		accept && !core.asleep |=> (state_reg == SIE_ENTRY) [*4] ##1 vec_valid_reg) // RULE_19
		else $error("entry not four cycles");
	a_entry_clears_i: assert property (@(posedge clk_sys) disable iff (reset)
		accept |=> !status_reg[`SIE_STATUS_WORD_I_BIT]) // RULE_09
		else $error("global enable not cleared on entry");
	a_return_from_interrupt_sets_i: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == SIE_IDLE && core.insn_done && core.op == SIE_OP_RETURN_FROM_INTERRUPT && !accept
		|-> ##5 status_reg[`SIE_STATUS_WORD_I_BIT] && sp_reg == $past(sp_reg, 5) + 16'h0002) // RULE_22
		else $error("return did not restore enable and pointer");
	a_cli_blocks: assert property (@(posedge clk_sys) disable iff (reset)
		core.cli |-> !accept) // RULE_17
		else $error("interrupt taken with clear-enable");
	a_need_enable: assert property (@(posedge clk_sys) disable iff (reset)
		accept |-> enable_reg[pick] && status_reg[`SIE_STATUS_WORD_I_BIT]) // RULE_05
		else $error("interrupt taken without enables");
	a_sei_delay: assert property (@(posedge clk_sys) disable iff (reset)
		core.sei && core.insn_done |=> !accept) // RULE_18
		else $error("interrupt right after set-enable");
	a_flag_cleared: assert property (@(posedge clk_sys) disable iff (reset)
		accept && !src_is_level[pick] && !src_event[pick] |=> !flag_reg[$past(pick)]) // RULE_11
		else $error("flag not cleared on vectoring");
	a_wake_extra: assert property (@(posedge clk_sys) disable iff (reset)
		accept && core.asleep |=> (state_reg == SIE_WAKE) [*4] ##1 state_reg == SIE_ENTRY) // RULE_21
		else $error("wake entry not four extra cycles");
endmodule // sie_core
`default_nettype wire

/* File: sie_stack_mem.sv */
// data memory model holding the stack, seen from the stack port
`timescale 1ns/1ps
`default_nettype none
module sie_stack_mem (
	input  wire logic        clk_sys,
	input  wire logic [15:0] stack_addr,
	input  wire logic        stack_wr,
	input  wire logic        stack_rd,
	input  wire logic [7:0]  stack_wdata,
	output logic [7:0]       stack_rdata
);
	logic [7:0] mem [0:2047];
	logic [7:0] last_reg;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// only the low eleven address bits decode: the top of data memory fits below 0x0800
	always_ff @(posedge clk_sys) begin
		if (stack_wr)
			mem[stack_addr[10:0]] <= stack_wdata;
		if (stack_rd)
			last_reg <= mem[stack_addr[10:0]];
	end

	// unselected: inverse of last value, so a stale byte never looks valid
	assign stack_rdata = stack_rd ? mem[stack_addr[10:0]] : ~last_reg;
endmodule // sie_stack_mem
`default_nettype wire

/* File: stack_and_interrupt_entry_tb.sv */
// self-checking testbench for the stack and interrupt entry block
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.svh"
module stack_and_interrupt_entry_tb;
	import sie_pkg::*;
	localparam int DLY = 2;
	logic          clk_sys;
	logic          reset;
	sie_io_s       io;
	sie_core_s     core;
	sie_src_t      src_event;
	sie_src_t      src_level;
	sie_src_t      src_is_level;
	logic          lock_app;
	logic          lock_boot;
	logic          in_boot;
	logic          fuse;
	logic [7:0]    stack_rdata;
	logic [7:0]    io_rdata;
	logic [15:0]   stack_addr;
	logic          stack_wr;
	logic          stack_rd;
	logic [7:0]    stack_wdata;
	logic          irq_busy;
	logic          vector_valid;
	logic [12:0]   vector_pc;
	logic [12:0]   reset_pc;
	logic [12:0]   return_pc;
	logic          return_valid;
	logic [7:0]    status_word;
	int            n_fail;
	int            n_tests;

	sie_core u_sie_core (.clk_sys(clk_sys), .reset(reset), .io(io), .core(core), .src_event(src_event),
		.src_level(src_level), .src_is_level(src_is_level), .boot_reset_fuse(fuse), .irq_lock_app(lock_app),
		.irq_lock_boot(lock_boot), .pc_in_boot(in_boot), .stack_rdata(stack_rdata), .io_rdata(io_rdata),
		.stack_addr(stack_addr), .stack_wr(stack_wr), .stack_rd(stack_rd), .stack_wdata(stack_wdata),
		.irq_busy(irq_busy), .vector_valid(vector_valid), .vector_pc(vector_pc), .reset_pc(reset_pc),
		.return_pc(return_pc), .return_valid(return_valid), .status_word(status_word));
	sie_stack_mem u_sie_stack_mem (.clk_sys(clk_sys), .stack_addr(stack_addr), .stack_wr(stack_wr),
		.stack_rd(stack_rd), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));

	always #12.5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// an idle edge first, so back-to-back calls never drive io twice in one step
	task automatic io_wr(input logic [5:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		#DLY io = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk_sys);
		#DLY io = '0;
	endtask

	task automatic rd_chk(input logic [5:0] addr, input logic [7:0] exp);
		@(posedge clk_sys);
		#DLY io = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk_sys);
		#DLY io = '0;
		check({8'h00, io_rdata}, {8'h00, exp});
	endtask

	// one instruction ends; busy is looked at once the edge has landed
	task automatic step(input sie_op_e op, input logic cli, input logic sei, input logic slp);
		@(posedge clk_sys);
		#DLY core = '{op: op, insn_done: 1'b1, cli: cli, sei: sei, asleep: slp, pc: 13'h0123};
		@(posedge clk_sys);
		#DLY core = '{op: SIE_OP_NONE, insn_done: 1'b0, cli: 1'b0, sei: 1'b0, asleep: 1'b0, pc: 13'h0123};
	endtask

	task automatic count_to(input bit ret, input logic [15:0] exp_n);
		int n;
		n = 0;
		while (((ret ? return_valid : vector_valid) !== 1'b1) && n < 30) begin
			@(posedge clk_sys);
			#DLY n++;
		end
		check(16'(n), exp_n);
	endtask

	task automatic event_on(input sie_src_t bits);
		src_event = bits;
		@(posedge clk_sys);
		#DLY src_event = '0;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		io = '0;
		core = '{op: SIE_OP_NONE, insn_done: 1'b0, cli: 1'b0, sei: 1'b0, asleep: 1'b0, pc: 13'h0123};
		src_event = '0;
		src_level = '0;
		src_is_level = 8'h10;
		lock_app = 1'b0;
		lock_boot = 1'b0;
		in_boot = 1'b0;
		fuse = 1'b1;
		n_fail = 0;
		n_tests = 0;
		repeat (16) @(posedge clk_sys);
		#DLY reset = 1'b0;
		@(posedge clk_sys);
		#DLY check({3'h0, reset_pc}, 16'h1C00);
		check(stack_addr, `SIE_TOP_OF_DATA);
		fuse = 1'b0;
		@(posedge clk_sys);
		#DLY check({3'h0, reset_pc}, 16'h0000);
		rd_chk(`SIE_IO_ADDR_SPL, 8'hFF);
		rd_chk(`SIE_IO_ADDR_SPH, 8'h04);
		rd_chk(6'h00, 8'h00);
		$display("test reset done");

		// software places the stack well above 0x0100
		io_wr(`SIE_IO_ADDR_SPL, 8'h80);
		check(stack_addr, 16'h0480);
		step(SIE_OP_PUSH1, 1'b0, 1'b0, 1'b0);
		check(stack_addr, 16'h047F);
		step(SIE_OP_POP1, 1'b0, 1'b0, 1'b0);
		check(stack_addr, 16'h0480);
		step(SIE_OP_CALL, 1'b0, 1'b0, 1'b0);
		check(stack_addr, 16'h047E);
		step(SIE_OP_RET, 1'b0, 1'b0, 1'b0);
		check(stack_addr, 16'h0480);
		$display("test pointer done");

		event_on(8'h08);
		rd_chk(`SIE_IO_ADDR_FLAGS, 8'h08);
		io_wr(`SIE_IO_ADDR_FLAGS, 8'h00);
		rd_chk(`SIE_IO_ADDR_FLAGS, 8'h08);
		io_wr(`SIE_IO_ADDR_FLAGS, 8'h08);
		rd_chk(`SIE_IO_ADDR_FLAGS, 8'h00);
		$display("test flags done");

		io_wr(`SIE_IO_ADDR_ENABLES, 8'h04);
		event_on(8'h04);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		step(SIE_OP_NONE, 1'b0, 1'b1, 1'b0);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		count_to(1'b0, 16'h0004);
		check({3'h0, vector_pc}, 16'h0006);
		check({15'h0, status_word[7]}, 16'h0000);
		check(stack_addr, 16'h047E);
		check({8'h00, u_sie_stack_mem.mem[11'h480]}, 16'h0023);
		// handler keeps its own copy of the status word
		rd_chk(`SIE_IO_ADDR_STATUS_WORD, 8'h00);
		rd_chk(`SIE_IO_ADDR_FLAGS, 8'h00);
		$display("test entry done");

		io_wr(`SIE_IO_ADDR_ENABLES, 8'h26);
		event_on(8'h22);
		step(SIE_OP_RETURN_FROM_INTERRUPT, 1'b0, 1'b0, 1'b0);
		count_to(1'b1, 16'h0004);
		check({3'h0, return_pc}, 16'h0123);
		check({15'h0, status_word[7]}, 16'h0001);
		check(stack_addr, 16'h0480);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		count_to(1'b0, 16'h0004);
		check({3'h0, vector_pc}, 16'h0004);
		step(SIE_OP_RETURN_FROM_INTERRUPT, 1'b0, 1'b0, 1'b0);
		count_to(1'b1, 16'h0004);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		step(SIE_OP_NONE, 1'b1, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		check({15'h0, status_word[7]}, 16'h0000);
		$display("test return done");

		io_wr(`SIE_IO_ADDR_STATUS_WORD, 8'h80);
		lock_app = 1'b1;
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		in_boot = 1'b1;
		lock_boot = 1'b1;
		lock_app = 1'b0;
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		// in the boot region only the boot lock counts, so this entry must go ahead
		lock_boot = 1'b0;
		lock_app = 1'b1;
		io_wr(`SIE_IO_ADDR_CTRL, 8'h02);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b1);
		count_to(1'b0, 16'h0008);
		check({3'h0, vector_pc}, 16'h1C0C);
		step(SIE_OP_RETURN_FROM_INTERRUPT, 1'b0, 1'b0, 1'b0);
		count_to(1'b1, 16'h0004);
		$display("test sleep done");

		lock_app = 1'b0;
		in_boot = 1'b0;
		io_wr(`SIE_IO_ADDR_ENABLES, 8'h00);
		src_level = 8'h10;
		repeat (2) @(posedge clk_sys);
		#DLY src_level = 8'h00;
		io_wr(`SIE_IO_ADDR_ENABLES, 8'h10);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		check({15'h0, irq_busy}, 16'h0000);
		src_level = 8'h10;
		step(SIE_OP_NONE, 1'b0, 1'b0, 1'b0);
		count_to(1'b0, 16'h0004);
		check({3'h0, vector_pc}, 16'h1C0A);
		src_level = 8'h00;
		$display("test level done");
		finish_test();
	end

	initial begin
		#(25 * 4000);
		n_fail++;
		finish_test();
	end
endmodule // stack_and_interrupt_entry_tb
`default_nettype wire
